// ---- hw/lpg_pkg.sv ----
/*
  Shared constants for the laser modulation and gate controller: clock rate,
  base-frequency limits, tickle timing, warm-up time and reset defaults.
  Assumes a single 200 MHz system clock and a synchronous active-high reset.
*/
`default_nettype none

package lpg_pkg;

  // System clock.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Width of every period and high-time count in clock cycles.
  localparam int unsigned CNT_W = 16;

  // Base frequency, default and upper limit.
  localparam int unsigned BASE_FREQ_HZ = 5_000;
  localparam int unsigned MAX_FREQ_HZ = 20_000;
  localparam logic [CNT_W-1:0] DEF_PERIOD_CYC = CNT_W'(CLK_HZ / BASE_FREQ_HZ);
  // Shortest period rounds up so the frequency never passes the limit.
  localparam logic [CNT_W-1:0] MIN_PERIOD_CYC =
    CNT_W'((CLK_HZ + MAX_FREQ_HZ - 1) / MAX_FREQ_HZ);

  // Duty after reset is zero, so only tickles are emitted before software asks.
  localparam logic [CNT_W-1:0] DEF_HIGH_CYC = 16'h0000;

  // Tickle pulse: 1000 ns long, every 200 us.
  localparam int unsigned TICKLE_LEN_NS = 1_000;
  localparam int unsigned TICKLE_PERIOD_US = 200;
  localparam logic [CNT_W-1:0] TICKLE_LEN_CYC =
    CNT_W'((TICKLE_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] TICKLE_PERIOD_CYC =
    CNT_W'((TICKLE_PERIOD_US * 1_000) / CLK_PERIOD_NS);

  // Tickle-only warm-up after reset: at least 2000 ms.
  localparam int unsigned WARMUP_MS = 2_000;
  localparam int unsigned WARMUP_CYC =
    (WARMUP_MS * ((1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS));
  localparam int unsigned WARM_W = 32;

  // Gate pull mode after reset: pull-up (normally on).
  localparam logic DEF_PULL_DOWN = 1'b0;

  // Modulator states.
  typedef enum logic [1:0] {
    LPG_MOD_OFF,
    LPG_MOD_HIGH,
    LPG_MOD_LOW,
    LPG_MOD_CW
  } lpg_mod_state_type;

endpackage : lpg_pkg

`default_nettype wire

// ---- hw/lpg_sync3.sv ----
/*
  Three-stage synchroniser for a group of pin inputs.
  Assumes the inputs are asynchronous to ref_clk; a change is taken only when
  the second and third stages agree, the first stage is read by nothing else.
*/
`timescale 1ns/100ps
`default_nettype none

module lpg_sync3 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;

  // Shift chain; only s2 samples s1.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Per bit, accept the new level only once two late stages agree.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_ff <= RST_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          out_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign sync_out = out_ff;

endmodule // lpg_sync3

`default_nettype wire

// ---- hw/lpg_tickle_gen.sv ----
/*
  Tickle pulse generator for the laser's modulation input.
  Assumes mod_high is a registered level that is high while the modulator
  holds the output high; tickles only appear while it is low.
*/
`timescale 1ns/100ps
`default_nettype none

module lpg_tickle_gen
  import lpg_pkg::*;
#(
  parameter logic [CNT_W-1:0] PERIOD_CYC = TICKLE_PERIOD_CYC,
  parameter logic [CNT_W-1:0] LEN_CYC = TICKLE_LEN_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic mod_high,
  output logic tickle
);

  logic [CNT_W-1:0] gap_ff;
  logic [CNT_W-1:0] len_ff;
  logic tickle_ff;

  // Gap timer restarts on every high phase, so the first tickle lands one
  // tickle period after the falling edge.
  always_ff @(posedge ref_clk) begin
    if (srst || mod_high) begin
      gap_ff <= '0;
    end else if (gap_ff == PERIOD_CYC - 16'h0001) begin
      gap_ff <= '0;
    end else begin
      gap_ff <= gap_ff + 16'h0001;
    end
  end

  // Pulse stretch; a high phase cuts any tickle short.
  always_ff @(posedge ref_clk) begin
    if (srst || mod_high) begin
      tickle_ff <= 1'b0;
      len_ff <= '0;
    end else if (gap_ff == PERIOD_CYC - 16'h0001) begin
      tickle_ff <= 1'b1;
      len_ff <= LEN_CYC - 16'h0001;
    end else if (len_ff != '0) begin
      len_ff <= len_ff - 16'h0001;
    end else begin
      tickle_ff <= 1'b0;
    end
  end

  assign tickle = tickle_ff;

endmodule // lpg_tickle_gen

`default_nettype wire

// ---- hw/lpg_top.sv ----
/*
  Host-side controller for the single modulation input of an RF-excited gas
  laser: base-frequency PWM, continuous-wave mode, external gate with pull
  mode, tickle pulses in off time and a tickle-only warm-up after reset.
  Assumes a 200 MHz ref_clk, synchronous srst, an asynchronous gate pin with
  a driven indication from its pad, and configuration from local logic.
*/
`timescale 1ns/100ps
`default_nettype none

module lpg_top
  import lpg_pkg::*;
#(
  parameter int unsigned WARMUP_CYCLES = WARMUP_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic gate_pin,
  input wire logic gate_pin_driven,
  input wire logic cfg_load,
  input wire logic [CNT_W-1:0] cfg_period,
  input wire logic [CNT_W-1:0] cfg_high,
  input wire logic cfg_cw,
  input wire logic cfg_pull_down,
  output logic laser_pwm,
  output logic warm_done,
  output logic beam_on,
  output logic cw_active,
  output logic gate_active,
  output logic cfg_clamped
);

  // Synchronised pin levels.
  logic gate_sync;
  logic driven_sync;

  // Configuration as written by local logic.
  logic [CNT_W-1:0] period_ff;
  logic [CNT_W-1:0] high_ff;
  logic cw_ff;
  logic pull_down_ff;
  logic clamped_ff;

  // Configuration in use for the current base period.
  logic [CNT_W-1:0] act_period_ff;
  logic [CNT_W-1:0] act_high_ff;

  // Gate, warm-up and modulator state.
  logic gate_eff_ff;
  logic [WARM_W-1:0] warm_cnt_ff;
  logic warm_done_ff;
  lpg_mod_state_type state_ff;
  lpg_mod_state_type nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic load_period;
  logic beam_req;
  logic mod_high_ff;
  logic tickle;
  logic laser_pwm_ff;
  logic beam_on_ff;
  logic cw_active_ff;

  // Clamp helpers for a configuration write.
  logic [CNT_W-1:0] clip_period;
  logic [CNT_W-1:0] clip_high;
  logic clip_hit;

  // The gate and its driven flag come from a pad, so both are resynchronised.
  // Reset value models an undriven low pin.
  // Both bits share one chain but each bit is accepted on its own, so a pin that is
  // driven and raised in the same cycle can be seen as two changes rather than as one.
  // A disconnected gate is reported by the pad as not driven, which is what
  // lets the pull mode decide its meaning below.
  lpg_sync3 #(
    .WIDTH(2),
    .RST_VAL(2'h0)
  ) u_gate_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in({gate_pin_driven, gate_pin}),
    .sync_out({driven_sync, gate_sync})
  );

  // Period is clamped to the shortest legal one; high time never passes the
  // period, so 100% is written as high equal to period.
  // A write below the limit is raised rather than refused, and cfg_clamped
  // tells local logic that its request was changed.
  // Zero high time is legal and gives a beam that only carries tickles.
  always_comb begin
    clip_period = cfg_period;
    clip_high = cfg_high;
    clip_hit = 1'b0;
    if (cfg_period < MIN_PERIOD_CYC) begin
      clip_period = MIN_PERIOD_CYC;
      clip_hit = 1'b1;
    end
    if (cfg_high > clip_period) begin
      clip_high = clip_period;
      clip_hit = 1'b1;
    end
  end

  // Configuration registers; reset gives 5 kHz, zero duty and pull-up mode.
  // The pull mode acts at once; continuous-wave select does too except in HIGH, which
  // finishes its high phase first; period and high time wait for the next period boundary.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      period_ff <= DEF_PERIOD_CYC;
      high_ff <= DEF_HIGH_CYC;
      cw_ff <= 1'b0;
      pull_down_ff <= DEF_PULL_DOWN;
      clamped_ff <= 1'b0;
    end else if (cfg_load) begin
      period_ff <= clip_period;
      high_ff <= clip_high;
      cw_ff <= cfg_cw;
      pull_down_ff <= cfg_pull_down;
      clamped_ff <= clip_hit;
    end
  end

  // Effective gate. Pull-down needs a driven high level; pull-up also
  // accepts a pin that nobody drives.
  // The pull mode is applied after the synchroniser, so a mode change acts
  // on the next clock instead of waiting out the pin delay.
  // A shorted gate reads as a driven low and stays off in both modes.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gate_eff_ff <= 1'b0;
    end else if (pull_down_ff) begin
      gate_eff_ff <= gate_sync & driven_sync;
    end else begin
      gate_eff_ff <= gate_sync | ~driven_sync;
    end
  end

  // Warm-up timer. Modulation stays locked out until it has run out, which
  // costs two seconds after every reset but protects the RF stage.
  // Tickles are not held back during this time; only the beam request is.
  // The counter stops once done, so it cannot wrap and re-arm the lockout.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      warm_cnt_ff <= '0;
      warm_done_ff <= 1'b0;
    end else if (!warm_done_ff) begin
      if (warm_cnt_ff == WARM_W'(WARMUP_CYCLES - 1)) begin
        warm_done_ff <= 1'b1;
      end else begin
        warm_cnt_ff <= warm_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // Beam is wanted only after warm-up and while the gate is asserted.
  assign beam_req = warm_done_ff & gate_eff_ff;

  // Modulator. A base period runs from cnt 0 to act_period-1; the first
  // act_high cycles of it are high. New settings are taken only at a period
  // boundary so a write never makes a runt pulse.
  // OFF: no beam wanted, the output carries tickles only.
  // HIGH: the high part of a modulated period.
  // LOW: the low part of a modulated period; a long one still gets tickles.
  // CW: continuous-wave, output held high for as long as the gate stays on and cw_ff stays set.
  // Every exit to OFF from HIGH or LOW happens with the output low or at the end of a
  // high phase, so no pulse is shortened; CW leaves at once when the gate or cw_ff drops.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    load_period = 1'b0;
    unique case (state_ff)
      LPG_MOD_OFF: begin
        nxt_cnt = '0;
        if (beam_req && cw_ff) begin
          nxt_state = LPG_MOD_CW;
        end else if (beam_req) begin
          load_period = 1'b1;
          nxt_state = (high_ff == '0) ? LPG_MOD_LOW : LPG_MOD_HIGH;
        end
      end
      LPG_MOD_HIGH: begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (cnt_ff == act_high_ff - 16'h0001) begin
          if (!beam_req || cw_ff) begin
            // The high phase is complete; only now may the gate end it.
            nxt_state = LPG_MOD_OFF;
          end else if (act_high_ff == act_period_ff) begin
            // Full duty: roll straight into the next period.
            load_period = 1'b1;
            nxt_cnt = '0;
            nxt_state = (high_ff == '0) ? LPG_MOD_LOW : LPG_MOD_HIGH;
          end else begin
            nxt_state = LPG_MOD_LOW;
          end
        end
      end
      LPG_MOD_LOW: begin
        nxt_cnt = cnt_ff + 16'h0001;
        if (!beam_req || cw_ff) begin
          // Already low, so leaving now cannot cut a pulse.
          nxt_state = LPG_MOD_OFF;
          nxt_cnt = '0;
        end else if (cnt_ff == act_period_ff - 16'h0001) begin
          load_period = 1'b1;
          nxt_cnt = '0;
          nxt_state = (high_ff == '0) ? LPG_MOD_LOW : LPG_MOD_HIGH;
        end
      end
      LPG_MOD_CW: begin
        nxt_cnt = '0;
        if (!beam_req || !cw_ff) begin
          nxt_state = LPG_MOD_OFF;
        end
      end
    endcase
  end

  // Modulator state and phase counter.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_ff <= LPG_MOD_OFF;
      cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Settings latched for the period that is starting.
  // Holding a copy here lets local logic rewrite the configuration at any
  // time without changing the length of the period already running.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      act_period_ff <= DEF_PERIOD_CYC;
      act_high_ff <= DEF_HIGH_CYC;
    end else if (load_period) begin
      act_period_ff <= period_ff;
      act_high_ff <= high_ff;
    end
  end

  // High-phase flag for the tickle generator and the output stage.
  // It follows the next state, so it lines up with state_ff and the output
  // register adds exactly one more cycle of delay.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mod_high_ff <= 1'b0;
    end else begin
      mod_high_ff <= (nxt_state == LPG_MOD_HIGH) || (nxt_state == LPG_MOD_CW);
    end
  end

  // Tickles fill every low time longer than one tickle period, in modulated and in continuous-wave use.
  // The generator restarts its gap on each high phase, which places the
  // first tickle one tickle period after the falling edge of every high phase.
  lpg_tickle_gen u_tickle (
    .ref_clk(ref_clk),
    .srst(srst),
    .mod_high(mod_high_ff),
    .tickle(tickle)
  );

  // Output stage: beam high phase or a tickle, otherwise low. The tickle
  // generator is cleared one cycle after a high phase starts, so a tickle then running joins that pulse.
  // Registering the merge keeps glitches off the laser input, at the cost of
  // one cycle of latency on every edge.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      laser_pwm_ff <= 1'b0;
    end else begin
      laser_pwm_ff <= mod_high_ff | tickle;
    end
  end

  // Status flags, registered so every output comes from a flip-flop.
  // They trail the modulator state by one cycle; local logic that needs the
  // exact edge should watch laser_pwm instead.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      beam_on_ff <= 1'b0;
      cw_active_ff <= 1'b0;
    end else begin
      beam_on_ff <= (state_ff != LPG_MOD_OFF);
      cw_active_ff <= (state_ff == LPG_MOD_CW);
    end
  end

  assign laser_pwm = laser_pwm_ff;
  assign warm_done = warm_done_ff;
  assign beam_on = beam_on_ff;
  assign cw_active = cw_active_ff;
  assign gate_active = gate_eff_ff;
  assign cfg_clamped = clamped_ff;

endmodule // lpg_top

`default_nettype wire

// ---- test/lpg_laser_model.sv ----
/*
  Behavioural model of the laser's single modulation input.
  Assumes laser_pwm is the controller's registered output on ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module lpg_laser_model #(
  parameter int unsigned WARM_NEED = 100,
  parameter int unsigned LASE_CYC = 600
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic laser_pwm,
  output var logic [15:0] optic_lvl,
  output var logic misuse
);
  logic [31:0] age_ff;
  logic [15:0] run_ff;

  // Optical level lags the input; a shift of 14 gives roughly an 82 us constant.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      optic_lvl <= 16'h0000;
    end else if (laser_pwm) begin
      optic_lvl <= optic_lvl + ((16'hFFFF - optic_lvl) >> 14);
    end else begin
      optic_lvl <= optic_lvl - (optic_lvl >> 14);
    end
  end

  // A lasing pulse before the warm-up has run is flagged as a misuse.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      age_ff <= 32'h0;
      run_ff <= 16'h0;
      misuse <= 1'b0;
    end else begin
      age_ff <= age_ff + 32'h1;
      run_ff <= laser_pwm ? run_ff + 16'h1 : 16'h0;
      // A pulse longer than LASE_CYC cycles (three tickles) that began before warm-up had run.
      if (run_ff > LASE_CYC && age_ff < WARM_NEED + LASE_CYC) begin
        misuse <= 1'b1;
      end
    end
  end
endmodule // lpg_laser_model

`default_nettype wire

// ---- test/lpg_top_assertions.sv ----
/*
  Checker on the ports of lpg_top.
  Assumes one clock, ref_clk, and the synchronous active-high srst.
*/
`timescale 1ns/100ps
`default_nettype none

module lpg_top_assertions
  import lpg_pkg::*;
#(
  parameter int unsigned WARMUP_CYCLES = WARMUP_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic laser_pwm,
  input wire logic warm_done,
  input wire logic beam_on,
  input wire logic cw_active,
  input wire logic gate_active
);
  logic [31:0] wcnt_ff;
  logic [31:0] lo_run_ff;
  logic [15:0] hi_run_ff;
  logic [7:0] off_run_ff;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  // Run lengths; the off counter saturates so long idle stretches stay valid.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wcnt_ff <= 32'h0;
      lo_run_ff <= 32'h0;
      hi_run_ff <= 16'h0;
      off_run_ff <= 8'h00;
    end else begin
      wcnt_ff <= wcnt_ff + 32'h1;
      lo_run_ff <= laser_pwm ? 32'h0 : lo_run_ff + 32'h1;
      hi_run_ff <= laser_pwm ? hi_run_ff + 16'h1 : 16'h0;
      off_run_ff <= beam_on ? 8'h00 : (off_run_ff == 8'hFF ? off_run_ff : off_run_ff + 8'h01);
    end
  end

  property p_rst_quiet;
    $fell(srst) |-> !laser_pwm && !warm_done && !beam_on && !cw_active;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not idle after reset");

  property p_warm_beam;
    !warm_done |-> !beam_on;
  endproperty
  a_warm_beam: assert property (p_warm_beam)
    else $error("modulation before warm-up end");

  property p_warm_time;
    $rose(warm_done) |-> wcnt_ff >= WARMUP_CYCLES;
  endproperty
  a_warm_time: assert property (p_warm_time)
    else $error("warm-up ended early");

  property p_warm_stay;
    warm_done |=> warm_done;
  endproperty
  a_warm_stay: assert property (p_warm_stay)
    else $error("warm-up flag dropped");

  property p_tickle_len;
    $fell(laser_pwm) && off_run_ff > 8'h04 |-> hi_run_ff == TICKLE_LEN_CYC;
  endproperty
  a_tickle_len: assert property (p_tickle_len)
    else $error("tickle pulse length wrong");

  property p_tickle_gap;
    !beam_on && !laser_pwm |-> lo_run_ff <= 32'(TICKLE_PERIOD_CYC) + 32'h4;
  endproperty
  a_tickle_gap: assert property (p_tickle_gap)
    else $error("tickle missing in off time");

  property p_cw_high;
    cw_active [*2] |-> laser_pwm;
  endproperty
  a_cw_high: assert property (p_cw_high)
    else $error("output low in continuous-wave");

  property p_beam_gate;
    $rose(beam_on) |-> $past(gate_active) || $past(gate_active, 2);
  endproperty
  a_beam_gate: assert property (p_beam_gate)
    else $error("beam started without gate");
endmodule // lpg_top_assertions

`default_nettype wire

// ---- test/laser_pwm_gate_control_tb.sv ----
/*
  Self-checking bench for lpg_top with the laser input model on its output.
  Assumes a shortened warm-up parameter and the package tickle constants.
*/
`timescale 1ns/100ps
`default_nettype none

module laser_pwm_gate_control_tb;
  import lpg_pkg::*;

  localparam int unsigned WARM = 100;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic gate_pin = 1'b0;
  logic gate_pin_driven = 1'b0;
  logic cfg_load = 1'b0;
  logic [CNT_W-1:0] cfg_period = 16'h9C40;
  logic [CNT_W-1:0] cfg_high = 16'h0000;
  logic cfg_cw = 1'b0;
  logic cfg_pull_down = 1'b0;
  logic laser_pwm, warm_done, beam_on, cw_active, gate_active, cfg_clamped, misuse, e;
  logic [15:0] optic_lvl;
  logic [15:0] lvl;
  int err_total = 0;
  int samples_checked = 0;
  int d, hi, lo;
  // Period, high, expected high, expected period, expected clamp flag.
  logic [15:0] rows [4][5] = '{'{16'h2710, 16'h09C4, 16'h09C4, 16'h2710, 16'h0},
    '{16'h1388, 16'h03E8, 16'h03E8, 16'h2710, 16'h1},
    '{16'h2AF8, 16'h2AF7, 16'h2AF7, 16'h2AF8, 16'h0},
    '{16'h2710, 16'h0001, 16'h0001, 16'h2710, 16'h0}};

  lpg_top #(.WARMUP_CYCLES(WARM)) i_lpg_top (.ref_clk(ref_clk), .srst(srst),
    .gate_pin(gate_pin), .gate_pin_driven(gate_pin_driven), .cfg_load(cfg_load),
    .cfg_period(cfg_period), .cfg_high(cfg_high), .cfg_cw(cfg_cw),
    .cfg_pull_down(cfg_pull_down), .laser_pwm(laser_pwm), .warm_done(warm_done),
    .beam_on(beam_on), .cw_active(cw_active), .gate_active(gate_active),
    .cfg_clamped(cfg_clamped));

  lpg_laser_model #(.WARM_NEED(WARM)) i_lpg_laser_model (.ref_clk(ref_clk), .srst(srst),
    .laser_pwm(laser_pwm), .optic_lvl(optic_lvl), .misuse(misuse));

  // Free-running 200 MHz clock.
  always #2.5 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Counts falling edges while the output holds v; bounded so a hang cannot stall.
  task automatic run(input logic v, output int n);
    n = 0;
    while (laser_pwm === v && n < 50000) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  task automatic load(input logic [15:0] p, input logic [15:0] h, input logic cw, input logic pd);
    cfg_period = p;
    cfg_high = h;
    cfg_cw = cw;
    cfg_pull_down = pd;
    cfg_load = 1'b1;
    @(negedge ref_clk);
    cfg_load = 1'b0;
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence: reset and warm-up, table rows, then the awkward cases.
  initial begin
    cyc(10);
    chk({warm_done, beam_on, laser_pwm}, 3'b000);
    cyc(6);
    srst = 1'b0;
    cyc(50);
    chk({warm_done, beam_on, laser_pwm}, 3'b000);
    cyc(WARM);
    chk({warm_done, beam_on, laser_pwm}, 3'b110);
    gate_pin_driven = 1'b1;
    foreach (rows[i]) begin
      gate_pin = 1'b0;
      run(1'b1, d);
      cyc(8);
      load(rows[i][0], rows[i][1], 1'b0, 1'b0);
      gate_pin = 1'b1;
      run(1'b0, d);
      chk(cfg_clamped, rows[i][4]);
      run(1'b1, hi);
      run(1'b0, lo);
      chk(hi, rows[i][2]);
      chk(hi + lo, rows[i][3]);
    end
    // A gate drop mid-pulse must let the pulse finish, then tickles follow.
    // Start from a closed gate so the new period begins at once.
    gate_pin = 1'b0;
    run(1'b1, d);
    cyc(8);
    load(16'h2710, 16'h0FA0, 1'b0, 1'b1);
    gate_pin = 1'b1;
    run(1'b1, d);
    run(1'b0, d);
    cyc(100);
    gate_pin = 1'b0;
    run(1'b1, hi);
    chk(hi + 100, 16'h0FA0);
    load(16'h2710, 16'h0FA0, 1'b1, 1'b1);
    run(1'b0, lo);
    run(1'b1, hi);
    chk(lo > TICKLE_PERIOD_CYC - 4 && lo < TICKLE_PERIOD_CYC + 3, 1'b1);
    chk(hi, TICKLE_LEN_CYC);
    gate_pin = 1'b1;
    cyc(10);
    chk({cw_active, laser_pwm}, 2'b11);
    lvl = optic_lvl;
    cyc(300);
    chk(laser_pwm, 1'b1);
    chk(optic_lvl > lvl, 1'b1);
    // Every pull mode, pin level and drive state in continuous-wave.
    for (int k = 0; k < 8; k++) begin
      gate_pin = k[1];
      gate_pin_driven = k[0];
      load(16'h2710, 16'h0FA0, 1'b1, k[2]);
      cyc(8);
      e = k[2] ? (k[1] & k[0]) : (k[1] | !k[0]);
      chk(gate_active, e);
      chk(laser_pwm, e);
    end
    chk(misuse, 1'b0);
    // Reset in mid-run: quiet outputs, then no beam until warm-up has run.
    srst = 1'b1;
    cyc(16);
    srst = 1'b0;
    chk({warm_done, beam_on, laser_pwm}, 3'b000);
    load(16'h2710, 16'h03E8, 1'b0, 1'b0);
    run(1'b0, d);
    chk(d, WARM + 1);
    run(1'b1, hi);
    chk(hi, 16'h03E8);
    chk(misuse, 1'b0);
    end_sim();
  end

  // Watchdog, about three times the expected run length.
  initial begin
    #1_500_000;
    err_total++;
    end_sim();
  end
endmodule // laser_pwm_gate_control_tb

bind lpg_top lpg_top_assertions #(.WARMUP_CYCLES(WARMUP_CYCLES)) i_lpg_top_assertions (
  .ref_clk(ref_clk), .srst(srst), .laser_pwm(laser_pwm), .warm_done(warm_done),
  .beam_on(beam_on), .cw_active(cw_active), .gate_active(gate_active));

`default_nettype wire
